/* focs_top.sv */
// Purpose: Set point mapping, switch outputs, error word and PWM guard.
// Assumes: All inputs are synchronous to core_clk; analogue value in mV.
// Notes:   Register port carries already decoded serial register accesses.
`timescale 1ns/1ps
module focs_top #(
   parameter int RPM_W = 14
) (
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [15:0]              reg_addr,
   input  wire logic [focs_pkg::DW-1:0]  reg_wdata,
   output logic      [focs_pkg::DW-1:0]  reg_rdata,
   output logic                          reg_ack,
   output logic                          reg_err,
   input  wire logic [13:0]              ain_mv,
   input  wire logic [RPM_W-1:0]         speed_max_rpm,
   input  wire logic [RPM_W-1:0]         speed_min_rpm,
   input  wire logic [RPM_W-1:0]         protect_limit_rpm,
   input  wire logic [RPM_W-1:0]         speed_meas_rpm,
   input  wire logic                     half_rev_tick,
   input  wire logic [focs_pkg::FW-1:0]  fault_cond,
   input  wire logic                     restart,
   output logic [RPM_W-1:0]              speed_cmd_rpm,
   output logic                          motor_run,
   output logic [focs_pkg::DW-1:0]       pwm_freq_khz,
   output logic                          switch_output_first,
   output logic                          switch_output_second,
   output logic [focs_pkg::FW-1:0]       flag_word
);
   import focs_pkg::*;

   // The speed arithmetic is sized for words of 8 to 16 bits only.
   if (RPM_W < 8 || RPM_W > 16) begin : g_rpm_w_check
      $error("RPM_W must lie between 8 and 16");
   end

   logic [DW-1:0]     passwd_q;
   logic [DW-1:0]     in_sel_q;
   logic [7:0]        out_sel_q;
   logic [DW-1:0]     ratio1_q;
   logic [DW-1:0]     ratio2_q;
   logic [DW-1:0]     pwm_q;
   logic [FW-1:0]     latch_q;
   logic [FW-1:0]     flags;
   logic              stop_err;
   logic              any_err;
   logic [RPM_W-1:0]  cmd_d;
   logic [RPM_W-1:0]  cmd_q;
   logic              pulse_q;
   logic              sw1_q;
   logic              sw2_q;
   logic [3:0]        fn1;
   logic [3:0]        fn2;
   logic              hit;
   logic [DW-1:0]     rdata_d;
   focs_motor_t       ms_q;

   // Proportional speed: max * mV / full scale, floored at minimum; zero below stop level, capped at limit.
   function automatic logic [RPM_W-1:0] scale_speed(
      input logic [13:0]      mv,
      input logic [RPM_W-1:0] vmax,
      input logic [RPM_W-1:0] vmin,
      input logic [RPM_W-1:0] vlim
   );
      logic [RPM_W+13:0] prod;
      logic [RPM_W-1:0]  top;
      logic [RPM_W-1:0]  r;
      prod = vmax * mv;
      top  = (vlim < vmax) ? vlim : vmax;
      if (mv < AIN_STOP_MV) begin
         r = '0;
      end else if (mv >= AIN_FULL_MV) begin
         r = vmax;
      end else begin
         r = RPM_W'(prod / AIN_FULL_MV);
         if (r < vmin) begin
            r = vmin;
         end
      end
      if (r > top) begin
         r = top;
      end
      return r;
   endfunction

   // Contact level for one function code; 1 means closed.
   function automatic logic contact(
      input logic [3:0] fn,
      input logic       err,
      input logic       above,
      input logic       at_set,
      input logic       pulse
   );
      logic c;
      case (fn)
         FN_OFF:       c = 1'b0;
         FN_ERROR:     c = !err;
         FN_ABOVE_MIN: c = above;
         FN_AT_SET:    c = at_set;
         FN_PULSE:     c = pulse;
         FN_ON:        c = 1'b1;
         default:      c = 1'b0;
      endcase
      return c;
   endfunction

   // Error and status word.
   assign flags = (latch_q & LATCH_MASK)
                | (fault_cond & ~LATCH_MASK);
   assign stop_err = |(flags & STOP_MASK);
   assign any_err = |(flags & ERROR_MASK);
   assign flag_word = flags;

   // A new fault in the restart cycle is kept, since the set wins.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_q <= '0;
      end else begin
         latch_q <= ((restart ? '0 : latch_q)
                  | fault_cond) & LATCH_MASK;
      end
   end

   // Motor state: fault wins over the set point.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_q <= MS_STOPPED;
      end else begin
         case (ms_q)
            MS_STOPPED: begin
               if (stop_err) begin
                  ms_q <= MS_FAULT;
               end else if (cmd_d != '0) begin
                  ms_q <= MS_RUNNING;
               end
            end
            MS_RUNNING: begin
               if (stop_err) begin
                  ms_q <= MS_FAULT;
               end else if (cmd_d == '0) begin
                  ms_q <= MS_STOPPED;
               end
            end
            MS_FAULT: begin
               if (!stop_err) begin
                  ms_q <= MS_STOPPED;
               end
            end
            default: ms_q <= MS_STOPPED;
         endcase
      end
   end

   assign cmd_d = stop_err ? '0
      : scale_speed(ain_mv, speed_max_rpm, speed_min_rpm,
                    protect_limit_rpm);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= '0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   assign speed_cmd_rpm = cmd_q;
   assign motor_run = (ms_q == MS_RUNNING);

   // Half-revolution ticks toggle the pulse, giving an even duty.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_q <= 1'b0;
      end else if (half_rev_tick) begin
         pulse_q <= !pulse_q;
      end
   end

   assign fn2 = out_sel_q[SEL2_LSB +: SELW];
   // The first output drops the pulse when both fields ask for it.
   assign fn1 = (out_sel_q[SEL1_LSB +: SELW] == FN_PULSE
                 && fn2 == FN_PULSE) ? FN_OFF
                : out_sel_q[SEL1_LSB +: SELW];

   logic above_min;
   logic at_set;
   logic [RPM_W+4:0] diff20;
   assign above_min = speed_meas_rpm > speed_min_rpm;
   assign diff20 = (RPM_W+5)'((speed_meas_rpm > cmd_q)
                   ? speed_meas_rpm - cmd_q
                   : cmd_q - speed_meas_rpm) * TOL_DIV;
   assign at_set = (cmd_q != '0)
                   && (diff20 <= (RPM_W+5)'(cmd_q));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sw1_q <= 1'b0;
         sw2_q <= 1'b0;
      end else begin
         // Separate fields; fn1 is forced off when both fields ask for the pulse.
         sw1_q <= contact(fn1, any_err, above_min, at_set,
                          pulse_q);
         sw2_q <= contact(fn2, any_err, above_min, at_set,
                          pulse_q);
      end
   end

   assign switch_output_first = sw1_q;
   assign switch_output_second = sw2_q;

   // Register file.
   assign hit = reg_addr == ADR_PASSWD || reg_addr == ADR_IN_SEL
             || reg_addr == ADR_OUT_SEL || reg_addr == ADR_RATIO1
             || reg_addr == ADR_RATIO2 || reg_addr == ADR_PWM
             || reg_addr == ADR_FLAGS;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         passwd_q  <= RST_PASSWD;
         in_sel_q  <= RST_IN_SEL;
         out_sel_q <= RST_OUT_SEL[7:0];
         ratio1_q  <= RST_RATIO1;
         ratio2_q  <= RST_RATIO2;
      end else if (reg_wr) begin
         case (reg_addr)
            ADR_PASSWD:  passwd_q  <= reg_wdata;
            ADR_IN_SEL:  in_sel_q  <= reg_wdata;
            ADR_OUT_SEL: out_sel_q <= reg_wdata[7:0];
            ADR_RATIO1:  ratio1_q  <= reg_wdata;
            ADR_RATIO2:  ratio2_q  <= reg_wdata;
            default:     passwd_q  <= passwd_q;
         endcase
      end
   end

   // A frequency change while spinning would upset the running drive.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_q <= RST_PWM_KHZ;
      end else if (reg_wr && reg_addr == ADR_PWM
                   && ms_q != MS_RUNNING) begin
         pwm_q <= reg_wdata;
      end
   end

   assign pwm_freq_khz = pwm_q;

   always_comb begin
      case (reg_addr)
         ADR_PASSWD:  rdata_d = passwd_q;
         ADR_IN_SEL:  rdata_d = in_sel_q;
         ADR_OUT_SEL: rdata_d = {8'h00, out_sel_q};
         ADR_RATIO1:  rdata_d = ratio1_q;
         ADR_RATIO2:  rdata_d = ratio2_q;
         ADR_PWM:     rdata_d = pwm_q;
         ADR_FLAGS:   rdata_d = {1'b0, flags};
         default:     rdata_d = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
         reg_ack   <= 1'b0;
         reg_err   <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : reg_rdata;
         reg_ack   <= (reg_rd || reg_wr) && hit;
         reg_err   <= (reg_rd || reg_wr) && !hit;
      end
   end

   property p_stop_below;
      @(posedge core_clk) disable iff (!reset_n)
      ain_mv < AIN_STOP_MV |=> speed_cmd_rpm == '0;
   endproperty
   a_stop_below: assert property (p_stop_below)
      else $error("speed command not zero below stop level");

   property p_limit;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> speed_cmd_rpm <= $past(protect_limit_rpm);
   endproperty
   a_limit: assert property (p_limit)
      else $error("speed command above protection limit");

   property p_on_off;
      @(posedge core_clk) disable iff (!reset_n)
      out_sel_q == 8'h50 |=> switch_output_first == 1'b0
                         && switch_output_second == 1'b1;
   endproperty
   a_on_off: assert property (p_on_off)
      else $error("fixed contact codes not honoured");

   property p_pulse_both;
      @(posedge core_clk) disable iff (!reset_n)
      out_sel_q == 8'h44 |=> !switch_output_first
                          && switch_output_second == $past(pulse_q);
   endproperty
   a_pulse_both: assert property (p_pulse_both)
      else $error("speed pulse not moved to second output");

   property p_err_out;
      @(posedge core_clk) disable iff (!reset_n)
      fn1 == FN_ERROR |=> switch_output_first == !$past(any_err);
   endproperty
   a_err_out: assert property (p_err_out)
      else $error("error contact wrong");

   property p_latch_hold;
      @(posedge core_clk) disable iff (!reset_n)
      fault_cond[10] ##1 !restart [*3] |-> flag_word[10];
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("blocked rotor flag lost without restart");

   property p_unlatched;
      @(posedge core_clk) disable iff (!reset_n)
      flag_word[4] == fault_cond[4] && flag_word[7] == fault_cond[7];
   endproperty
   a_unlatched: assert property (p_unlatched)
      else $error("self clearing flag does not follow condition");

   // The flag latches one edge after its condition; the stop follows it.
   property p_stop_err;
      @(posedge core_clk) disable iff (!reset_n)
      fault_cond[1] |=> ##1 !motor_run ##1 !motor_run;
   endproperty
   a_stop_err: assert property (p_stop_err)
      else $error("motor runs after overcurrent");

   property p_pwm_guard;
      @(posedge core_clk) disable iff (!reset_n)
      reg_wr && reg_addr == ADR_PWM && !motor_run
         |=> pwm_freq_khz == $past(reg_wdata);
   endproperty
   a_pwm_guard: assert property (p_pwm_guard)
      else $error("PWM write while stopped not taken");

   property p_pwm_hold;
      @(posedge core_clk) disable iff (!reset_n)
      motor_run |=> $stable(pwm_freq_khz);
   endproperty
   a_pwm_hold: assert property (p_pwm_hold)
      else $error("PWM frequency changed while running");

   c_run: cover property (@(posedge core_clk) motor_run);
   c_fault: cover property (@(posedge core_clk) ms_q == MS_FAULT);
   c_pwm: cover property (@(posedge core_clk)
      reg_wr && reg_addr == ADR_PWM && !motor_run);
endmodule // focs_top

/* focs_pkg.sv */
// Purpose: Shared constants for the fan output, configuration and error block.
// Assumes: Register addresses are the decoded serial register numbers.
// Notes:   Flag word bit positions follow the weight of each code.
package focs_pkg;
   localparam int          DW          = 16;
   localparam logic [15:0] ADR_PASSWD  = 16'h9C47;
   localparam logic [15:0] ADR_IN_SEL  = 16'h9C57;
   localparam logic [15:0] ADR_OUT_SEL = 16'h9C58;
   localparam logic [15:0] ADR_RATIO1  = 16'h9C59;
   localparam logic [15:0] ADR_RATIO2  = 16'h9C5A;
   localparam logic [15:0] ADR_PWM     = 16'h9C5B;
   localparam logic [15:0] ADR_FLAGS   = 16'h7531;
   localparam logic [15:0] RST_PASSWD  = 16'h0E75;
   localparam logic [15:0] RST_IN_SEL  = 16'h0FF0;
   localparam logic [15:0] RST_OUT_SEL = 16'h0021;
   localparam logic [15:0] RST_RATIO1  = 16'h01F4;
   localparam logic [15:0] RST_RATIO2  = 16'h0320;
   localparam logic [15:0] RST_PWM_KHZ = 16'h000A;
   localparam logic [15:0] OUT_SEL_USED = 16'h00FF;
   localparam int          SEL1_LSB    = 0;
   localparam int          SEL2_LSB    = 4;
   localparam int          SELW        = 4;
   localparam logic [3:0]  FN_OFF      = 4'h0;
   localparam logic [3:0]  FN_ERROR    = 4'h1;
   localparam logic [3:0]  FN_ABOVE_MIN = 4'h2;
   localparam logic [3:0]  FN_AT_SET   = 4'h3;
   localparam logic [3:0]  FN_PULSE    = 4'h4;
   localparam logic [3:0]  FN_ON       = 4'h5;
   localparam logic [13:0] AIN_STOP_MV = 14'h01F4;
   localparam logic [13:0] AIN_FULL_MV = 14'h2710;
   localparam logic [4:0]  TOL_DIV     = 5'h14;
   localparam int          FW          = 15;
   // Bits 0,1,2,5,6,10 latch; 8,9,11..14 are status only.
   localparam logic [14:0] LATCH_MASK  = 15'h0467;
   localparam logic [14:0] STOP_MASK   = 15'h046F;
   localparam logic [14:0] ERROR_MASK  = 15'h04FF;
   typedef enum logic [2:0] {
      MS_STOPPED = 3'b001,
      MS_RUNNING = 3'b010,
      MS_FAULT   = 3'b100
   } focs_motor_t;
endpackage

/* focs_fan_model.sv */
// Purpose: Fan motor stand-in that answers the speed command of the block.
// Assumes: Measured speed trails the command by a slip set by the bench.
// Notes:   Ticks stop while the motor is halted or the bench disables them.
`timescale 1ns/1ps
module focs_fan_model #(
   parameter int HALF_REV_CYC = 4
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        motor_run,
   input  wire logic        tick_en,
   input  wire logic [13:0] speed_cmd_rpm,
   input  wire logic [13:0] slip_rpm,
   output logic      [13:0] speed_meas_rpm,
   output logic             half_rev_tick
);
   int cnt_q;

   // A stopped rotor reads zero, so stale speed never fakes a running flag.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         speed_meas_rpm <= 14'h0000;
      end else begin
         speed_meas_rpm <= motor_run ? speed_cmd_rpm - slip_rpm : 14'h0000;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q         <= 0;
         half_rev_tick <= 1'b0;
      end else if (motor_run && tick_en) begin
         cnt_q         <= (cnt_q == HALF_REV_CYC - 1) ? 0 : cnt_q + 1;
         half_rev_tick <= (cnt_q == HALF_REV_CYC - 1);
      end else begin
         cnt_q         <= 0;
         half_rev_tick <= 1'b0;
      end
   end
endmodule // focs_fan_model

/* tb_focs_top.sv */
// Purpose: Self-checking bench for the fan output and error block.
// Assumes: Inputs change on the falling edge; one register access at a time.
// Notes:   Masks below restate the latch, stop and error columns of the flag table.
`timescale 1ns/1ps
module tb_focs_top;
   import focs_pkg::*;
   localparam logic [14:0] LAT_M = 15'h0467;
   localparam logic [14:0] STP_M = 15'h046F;
   localparam logic [14:0] ERR_M = 15'h04FF;
   logic        core_clk, reset_n, reg_wr, reg_rd, restart, tick_en;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, pwm_freq_khz, q_v;
   logic        reg_ack, reg_err, motor_run, half_rev_tick, ok;
   logic        switch_output_first, switch_output_second, pa, pb;
   logic [13:0] ain_mv, speed_max_rpm, speed_min_rpm, protect_limit_rpm;
   logic [13:0] speed_meas_rpm, speed_cmd_rpm, slip_rpm;
   logic [14:0] fault_cond, flag_word;
   logic [15:0] nt, na, nb;
   int          n_fail, checks_done, i, k, b;
   logic [13:0] slips [4] = '{14'h0000, 14'h01F4, 14'h0258, 14'h2328};
   logic [3:0]  e2 = 4'b0111;
   logic [3:0]  e3 = 4'b0011;

   focs_top uut (.core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
      .ain_mv(ain_mv), .speed_max_rpm(speed_max_rpm),
      .speed_min_rpm(speed_min_rpm), .protect_limit_rpm(protect_limit_rpm),
      .speed_meas_rpm(speed_meas_rpm), .half_rev_tick(half_rev_tick),
      .fault_cond(fault_cond), .restart(restart),
      .speed_cmd_rpm(speed_cmd_rpm), .motor_run(motor_run),
      .pwm_freq_khz(pwm_freq_khz), .switch_output_first(switch_output_first),
      .switch_output_second(switch_output_second), .flag_word(flag_word));

   focs_fan_model fan (.core_clk(core_clk), .reset_n(reset_n),
      .motor_run(motor_run), .tick_en(tick_en),
      .speed_cmd_rpm(speed_cmd_rpm), .slip_rpm(slip_rpm),
      .speed_meas_rpm(speed_meas_rpm), .half_rev_tick(half_rev_tick));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("counts checks=%0d fails=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Strobes are single-cycle pulses; the answer is awaited under a bound.
   task automatic access(input logic wr, input logic [15:0] a, d);
      int j;
      @(negedge core_clk);
      reg_wr    = wr;
      reg_rd    = !wr;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      for (j = 0; j < 4 && reg_ack !== 1'b1 && reg_err !== 1'b1; j++) begin
         @(negedge core_clk);
      end
      if (j == 4) begin
         n_fail++;
         complete_run();
      end
      ok  = reg_ack;
      q_v = reg_rdata;
   endtask

   task automatic rd(input logic [15:0] a, e, input logic ok_e);
      access(1'b0, a, 16'h0000);
      chk1(ok, ok_e);
      if (ok_e) chk16(q_v, e);
      if (!ok_e) chk1(reg_err, 1'b1);
   endtask

   task automatic wr(input logic [15:0] a, d);
      access(1'b1, a, d);
      chk1(ok, 1'b1);
   endtask

   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      {reset_n, reg_wr, reg_rd, restart, tick_en} = 5'h00;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      ain_mv = 14'h0000;
      speed_max_rpm = 14'h2710;
      speed_min_rpm = 14'h07D0;
      protect_limit_rpm = 14'h3FFF;
      slip_rpm = 14'h0000;
      fault_cond = 15'h0000;
      cyc(4);
      reset_n = 1'b1;
      cyc(2);
      rd(ADR_OUT_SEL, 16'h0021, 1'b1);
      rd(ADR_PWM, 16'h000A, 1'b1);
      chk16(pwm_freq_khz, 16'h000A);
      rd(ADR_PASSWD, 16'h0E75, 1'b1);
      rd(ADR_IN_SEL, 16'h0FF0, 1'b1);
      rd(ADR_RATIO1, 16'h01F4, 1'b1);
      rd(ADR_RATIO2, 16'h0320, 1'b1);
      rd(16'h9C50, 16'h0000, 1'b0);
      chk1(switch_output_first, 1'b1);
      chk1(switch_output_second, 1'b0);
      wr(ADR_RATIO2, 16'hA5C3);
      rd(ADR_RATIO2, 16'hA5C3, 1'b1);
      wr(ADR_PWM, 16'h0014);
      rd(ADR_PWM, 16'h0014, 1'b1);
      $display("test registers done");
      ain_mv = 14'h0190;
      cyc(3);
      chk16({2'h0, speed_cmd_rpm}, 16'h0000);
      chk1(motor_run, 1'b0);
      ain_mv = 14'h03E8;
      cyc(3);
      chk16({2'h0, speed_cmd_rpm}, 16'h07D0);
      ain_mv = 14'h2710;
      cyc(3);
      chk16({2'h0, speed_cmd_rpm}, 16'h2710);
      protect_limit_rpm = 14'h1770;
      cyc(3);
      chk16({2'h0, speed_cmd_rpm}, 16'h1770);
      protect_limit_rpm = 14'h3FFF;
      wr(ADR_PWM, 16'h0008);
      rd(ADR_PWM, 16'h0014, 1'b1);
      chk16(pwm_freq_khz, 16'h0014);
      $display("test speed done");
      wr(ADR_OUT_SEL, 16'h1232);
      rd(ADR_OUT_SEL, 16'h0032, 1'b1);
      for (i = 0; i < 4; i++) begin
         slip_rpm = slips[i];
         cyc(4);
         chk1(switch_output_first, e2[i]);
         chk1(switch_output_second, e3[i]);
      end
      slip_rpm = 14'h0000;
      wr(ADR_OUT_SEL, 16'h0050);
      cyc(2);
      chk1(switch_output_first, 1'b0);
      chk1(switch_output_second, 1'b1);
      wr(ADR_OUT_SEL, 16'h0076);
      cyc(2);
      chk1(switch_output_first, 1'b0);
      chk1(switch_output_second, 1'b0);
      for (k = 0; k < 2; k++) begin
         wr(ADR_OUT_SEL, k == 0 ? 16'h0004 : 16'h0044);
         cyc(2);
         {nt, na, nb} = 48'h0;
         pa = switch_output_first;
         pb = switch_output_second;
         tick_en = 1'b1;
         for (i = 0; i < 64; i++) begin
            @(negedge core_clk);
            if (i == 56) tick_en = 1'b0;
            nt += {15'h0, half_rev_tick};
            na += {15'h0, switch_output_first != pa};
            nb += {15'h0, switch_output_second != pb};
            pa = switch_output_first;
            pb = switch_output_second;
         end
         chk1(nt != 16'h0000, 1'b1);
         chk16(k == 0 ? na : nb, nt);
         chk16(k == 0 ? nb : na, 16'h0000);
      end
      $display("test switch outputs done");
      wr(ADR_OUT_SEL, 16'h0001);
      for (b = 0; b < 15; b++) begin
         fault_cond = 15'h0001 << b;
         cyc(4);
         chk1(flag_word[b], 1'b1);
         chk1(motor_run, !STP_M[b]);
         chk1(switch_output_first, !ERR_M[b]);
         rd(ADR_FLAGS, 16'h0001 << b, 1'b1);
         fault_cond = 15'h0000;
         cyc(4);
         chk1(flag_word[b], LAT_M[b]);
         chk1(motor_run, !LAT_M[b]);
         restart = 1'b1;
         cyc(1);
         restart = 1'b0;
         cyc(4);
         chk16({1'b0, flag_word}, 16'h0000);
         chk1(motor_run, 1'b1);
      end
      wr(ADR_FLAGS, 16'h7FFF);
      rd(ADR_FLAGS, 16'h0000, 1'b1);
      fault_cond = 15'h0001;
      cyc(4);
      chk1(flag_word[0], 1'b1);
      fault_cond = 15'h0000;
      reset_n = 1'b0;
      cyc(4);
      reset_n = 1'b1;
      cyc(2);
      chk16({1'b0, flag_word}, 16'h0000);
      chk16(pwm_freq_khz, 16'h000A);
      $display("test flags done");
      complete_run();
   end
endmodule // tb_focs_top
